// *** include/wocr_pkg.sv ***
package wocr_pkg;
  // register indices (printed offsets); the bus byte address is the index times four
  localparam logic [15:0] WOCR_IDX_CFG2 = 16'h001d; // second config index
  localparam logic [15:0] WOCR_IDX_CFG1 = 16'h001f; // first config index
  localparam logic [15:0] WOCR_IDX_OPT  = 16'hffcf; // option byte index
  localparam logic [17:0] WOCR_ADDR_CFG2 = {WOCR_IDX_CFG2, 2'b00};
  localparam logic [17:0] WOCR_ADDR_CFG1 = {WOCR_IDX_CFG1, 2'b00};
  localparam logic [17:0] WOCR_ADDR_OPT  = {WOCR_IDX_OPT, 2'b00};
  // reset and erased values
  localparam logic [7:0] WOCR_CFG_RST  = 8'h00; // volatile reset value
  localparam logic [7:0] WOCR_OPT_ERASED = 8'hff; // erased option byte
  // second register: bits 2 and 1 read zero
  localparam logic [7:0] WOCR_CFG2_WMASK = 8'hf9; // writable bits
  // stop recovery delays in internal oscillator cycles
  localparam int WOCR_REC_SHORT = 32;
  localparam int WOCR_REC_LONG  = 4096;
  // watchdog timeouts in internal oscillator cycles
  localparam int WOCR_WD_SHORT = (1 << 13) - (1 << 4);
  localparam int WOCR_WD_LONG  = (1 << 18) - (1 << 4);
  // first register fields
  typedef struct packed {
    logic watchdog_rate_select;      // bit 7
    logic monitor_stop_enable;       // bit 6
    logic monitor_reset_disable;     // bit 5
    logic supply_monitor_disable;    // bit 4
    logic regulator_monitor_disable; // bit 3
    logic short_recovery_select;     // bit 2
    logic stop_enable;               // bit 1
    logic watchdog_disable;          // bit 0
  } wocr_cfg1_t;
  // second register fields
  typedef struct packed {
    logic       int_osc_stop_disable; // bit 7
    logic       rc_osc_stop_enable;   // bit 6
    logic       crystal_stop_enable;  // bit 5
    logic [1:0] timebase_clk_sel;     // bits 4:3
    logic [1:0] zero_bits;            // bits 2:1
    logic       serial_clk_source;    // bit 0
  } wocr_cfg2_t;
  // clock source codes
  localparam logic [1:0] WOCR_TB_INT = 2'h0; // timebase from internal
  localparam logic [1:0] WOCR_TB_RC  = 2'h1; // timebase from rc
  localparam logic [1:0] WOCR_TB_XT  = 2'h2; // timebase from crystal
  localparam logic [1:0] WOCR_MO_INT = 2'h1; // main from internal
  localparam logic [1:0] WOCR_MO_RC  = 2'h2; // main from rc
  localparam logic [1:0] WOCR_MO_XT  = 2'h3; // main from crystal
endpackage

// *** rtl/wocr_regs.sv ***
// Overview of operation
// RULE1 - one software write per register per reset
// RULE2 - reset clears both volatile registers
// RULE3 - reads allowed at any time
// RULE4 - registers decoded at 001D and 001F
// RULE5 - software writes registers right after reset
// RULE6 - rate bit picks short or long watchdog timeout
// RULE7 - monitor runs in stop if enabled and powered
// RULE8 - software sets reset disable before stop
// RULE9 - reset disable bit blocks monitor resets
// RULE10 - disable bits turn off each monitor circuit
// RULE11 - recovery bit picks 32 or 4096 cycles
// RULE12 - pin reset exit always long recovery
// RULE13 - no short recovery with crystal clock; code does not check main_osc_sel
// RULE14 - short recovery leaves unprotected start-up window
// RULE15 - stop enable bit else stop opcode illegal
// RULE16 - watchdog disable bit stops watchdog
// RULE17 - internal oscillator halts in stop if set
// RULE18 - rc oscillator runs in stop if set
// RULE19 - option byte in flash, programmed only, erased ones
// RULE20 - crystal stop enable keeps crystal running
// RULE21 - timebase clock select routing
// RULE22 - serial clock from bus or oscillator
// RULE23 - option bits pick main oscillator, reset-proof
// RULE24 - write-used flag blocks further writes
// RULE25 - second register bits 2 and 1 zero
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module wocr_regs
  import wocr_pkg::*;
(
  input  wire logic        pclk,             // bus clock
  input  wire logic        presetn,          // async reset, low
  input  wire logic        psel,             // apb select
  input  wire logic        penable,          // apb access phase
  input  wire logic        pwrite,           // apb direction
  input  wire logic [31:0] paddr,            // apb byte address
  input  wire logic [31:0] pwdata,           // apb write data
  output logic      [31:0] prdata,           // apb read data
  output logic             pready,           // apb ready
  output logic             pslverr,          // apb error
  input  wire logic        opt_prog_we,      // flash programming strobe
  input  wire logic [7:0]  opt_prog_data,    // flash programmed byte
  input  wire logic        opt_erase,        // flash erase strobe
  input  wire logic        stop_mode,        // device is in stop
  input  wire logic        stop_exit_by_pin, // stop left via reset pin
  input  wire logic        monitor_reset_req,// voltage monitor request
  output logic             monitor_reset_out,// gated monitor reset
  output logic             supply_monitor_on,// supply monitor enabled
  output logic             regulator_monitor_on, // regulator monitor on
  output logic             monitor_in_stop,  // monitor runs in stop
  output logic             watchdog_enable,  // watchdog runs
  output logic [18:0]      watchdog_timeout, // watchdog cycles
  output logic [12:0]      recovery_cycles,  // stop exit delay
  output logic             unprotected_start,// window w/o monitor
  output logic             stop_opcode_legal,// stop allowed
  output logic             int_osc_run,      // internal osc running
  output logic             rc_osc_run,       // rc osc running
  output logic             crystal_run,      // crystal running
  output logic [1:0]       timebase_src,     // timebase clock select
  output logic             serial_clk_bus,   // serial clock from bus
  output logic [1:0]       main_osc_sel,     // main oscillator select
  output logic [7:0]       cfg1_out,         // first register value
  output logic [7:0]       cfg2_out          // second register value
);

  wocr_cfg1_t cfg1_q;     // first configuration register
  wocr_cfg2_t cfg2_q;     // second configuration register
  logic       used1_q;    // first register already written
  logic       used2_q;    // second register already written
  logic [7:0] opt_q = WOCR_OPT_ERASED; // option byte, powers up erased
  logic       wr_acc;     // write access phase
  logic       hit1;       // first register addressed
  logic       hit2;       // second register addressed
  logic       hit_opt;    // option byte addressed
  logic       mapped;     // any register addressed

  // address decode
  assign hit1    = paddr[17:0] == WOCR_ADDR_CFG1;   // [RULE4]
  assign hit2    = paddr[17:0] == WOCR_ADDR_CFG2;   // [RULE4]
  assign hit_opt = paddr[17:0] == WOCR_ADDR_OPT;
  assign mapped  = (hit1 | hit2 | hit_opt) && paddr[31:18] == 14'h0000;
  assign wr_acc  = psel & penable & pwrite & mapped;

  // zero wait state slave; unmapped gives error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // first register, written once per reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg1_q <= wocr_cfg1_t'(WOCR_CFG_RST);          // [RULE2]
    end else if (wr_acc && hit1 && !used1_q) begin   // [RULE1]
      cfg1_q <= wocr_cfg1_t'(pwdata[7:0]);
    end
  end

  // second register, written once; bits 2:1 stay zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg2_q <= wocr_cfg2_t'(WOCR_CFG_RST);          // [RULE2] [RULE20]
    end else if (wr_acc && hit2 && !used2_q) begin   // [RULE1]
      cfg2_q <= wocr_cfg2_t'(pwdata[7:0] & WOCR_CFG2_WMASK); // [RULE25]
    end
  end

  // write-used flags, re-armed only by reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      used1_q <= 1'b0;                                // [RULE24]
      used2_q <= 1'b0;
    end else begin
      if (wr_acc && hit1) begin
        used1_q <= 1'b1;                              // [RULE24]
      end
      if (wr_acc && hit2) begin
        used2_q <= 1'b1;                              // [RULE24]
      end
    end
  end

  // option byte: bus writes ignored, only flash program/erase
  // modelled with a reset-free flop so reset leaves it alone
  always_ff @(posedge pclk) begin
    if (opt_erase) begin
      opt_q <= WOCR_OPT_ERASED;                       // [RULE19]
    end else if (opt_prog_we) begin
      opt_q <= opt_q & opt_prog_data;                 // [RULE19] [RULE23]
    end
  end

  // read data, valid any time
  always_comb begin
    prdata = 32'h0000_0000;
    if (psel && !pwrite) begin                        // [RULE3]
      if (hit1) begin
        prdata[7:0] = cfg1_q;
      end else if (hit2) begin
        prdata[7:0] = cfg2_q;
      end else if (hit_opt) begin
        prdata[7:0] = opt_q;
      end
    end
  end

  // decoded controls for consuming modules
  always_comb begin
    monitor_reset_out    = monitor_reset_req &
                           ~cfg1_q.monitor_reset_disable;     // [RULE9]
    supply_monitor_on    = ~cfg1_q.supply_monitor_disable;    // [RULE10]
    regulator_monitor_on = ~cfg1_q.regulator_monitor_disable; // [RULE10]
    monitor_in_stop      = cfg1_q.monitor_stop_enable &
                           ~(cfg1_q.supply_monitor_disable &
                             cfg1_q.regulator_monitor_disable); // [RULE7]
    watchdog_enable      = ~cfg1_q.watchdog_disable;          // [RULE16]
    watchdog_timeout     = cfg1_q.watchdog_rate_select ?
                           19'(WOCR_WD_SHORT) : 19'(WOCR_WD_LONG); // [RULE6]
    recovery_cycles      = (cfg1_q.short_recovery_select &&
                            !stop_exit_by_pin) ?
                           13'(WOCR_REC_SHORT) : 13'(WOCR_REC_LONG);
    // above: pin reset forces long delay            [RULE11] [RULE12]
    unprotected_start    = cfg1_q.short_recovery_select &
                           ~monitor_in_stop;                  // [RULE14]
    stop_opcode_legal    = cfg1_q.stop_enable;                // [RULE15]
    int_osc_run          = ~(stop_mode &
                             cfg2_q.int_osc_stop_disable);    // [RULE17]
    rc_osc_run           = ~stop_mode | cfg2_q.rc_osc_stop_enable; // [RULE18]
    crystal_run          = ~stop_mode | cfg2_q.crystal_stop_enable; // [RULE20]
    timebase_src         = cfg2_q.timebase_clk_sel;           // [RULE21]
    serial_clk_bus       = cfg2_q.serial_clk_source;          // [RULE22]
    main_osc_sel         = opt_q[7:6];                        // [RULE23]
    cfg1_out             = cfg1_q;
    cfg2_out             = cfg2_q;
  end

  // one write only: a second write leaves value unchanged
  property once_only_p;
    @(posedge pclk) disable iff (!presetn)
      (used1_q && wr_acc && hit1) |=> $stable(cfg1_q);
  endproperty
  write_once_one_a : assert property (once_only_p) // [RULE1]
    else $error("first register changed after its write");
  write_once_two_a : assert property ( // [RULE1]
    @(posedge pclk) disable iff (!presetn)
      (used2_q && wr_acc && hit2) |=> $stable(cfg2_q))
    else $error("second register changed after its write");
  first_write_a : assert property ( // [RULE24]
    @(posedge pclk) disable iff (!presetn)
      (!used1_q && wr_acc && hit1) |=>
        used1_q && cfg1_q == $past(pwdata[7:0]))
    else $error("first write not taken");
  zero_bits_a : assert property ( // [RULE25]
    @(posedge pclk) disable iff (!presetn) cfg2_q.zero_bits == 2'h0)
    else $error("reserved bits nonzero");
  mon_gate_a : assert property ( // [RULE9]
    @(posedge pclk) disable iff (!presetn)
      cfg1_q.monitor_reset_disable |-> !monitor_reset_out)
    else $error("monitor reset passed while disabled");
  pin_long_a : assert property ( // [RULE12]
    @(posedge pclk) disable iff (!presetn)
      stop_exit_by_pin |-> recovery_cycles == 13'(WOCR_REC_LONG))
    else $error("pin exit not long recovery");
  wd_rate_a : assert property ( // [RULE6]
    @(posedge pclk) disable iff (!presetn)
      watchdog_timeout == (cfg1_q.watchdog_rate_select ?
        19'(WOCR_WD_SHORT) : 19'(WOCR_WD_LONG)))
    else $error("watchdog timeout wrong");
  opt_bus_a : assert property ( // [RULE19]
    @(posedge pclk) disable iff (!presetn)
      (!opt_prog_we && !opt_erase) |=> $stable(opt_q))
    else $error("option byte changed without programming");

  // steps of a first write: an unused register hit by a write access
  sequence first_wr_one_s;
    !used1_q && wr_acc && hit1;
  endsequence
  sequence first_wr_two_s;
    !used2_q && wr_acc && hit2;
  endsequence
  // the edge after it: flag set and the low bus byte taken with bits 2:1 cleared
  sequence taken_two_s;
    used2_q && cfg2_q == ($past(pwdata[7:0]) & WOCR_CFG2_WMASK);
  endsequence
  // second register takes its first write with bits 2:1 masked
  first_write_two_a : assert property ( // [RULE24] [RULE25]
    @(posedge pclk) disable iff (!presetn)
      first_wr_two_s |=> taken_two_s)
    else $error("second register first write not taken");
  // the single write is accepted without a bus error
  write_clean_a : assert property ( // [RULE1]
    @(posedge pclk) disable iff (!presetn)
      first_wr_one_s |-> pready && !pslverr)
    else $error("first write answered with an error");
  // write-used flags never drop between resets
  used_one_kept_a : assert property ( // [RULE24]
    @(posedge pclk) disable iff (!presetn)
      used1_q |=> used1_q)
    else $error("first write-used flag dropped");
  used_two_kept_a : assert property ( // [RULE24]
    @(posedge pclk) disable iff (!presetn)
      used2_q |=> used2_q)
    else $error("second write-used flag dropped");
  // first edge after reset release: registers cleared, flags re-armed
  reset_clear_a : assert property ( // [RULE2]
    @(posedge pclk) disable iff (!presetn)
      !$past(presetn) |-> cfg1_q == WOCR_CFG_RST &&
        cfg2_q == WOCR_CFG_RST && !used1_q && !used2_q)
    else $error("registers not cleared by reset");
  // reads return the register contents in the low byte at any time
  read_one_a : assert property ( // [RULE3]
    @(posedge pclk) disable iff (!presetn)
      (psel && !pwrite && hit1) |-> prdata == {24'h00_0000, cfg1_q})
    else $error("first register read wrong");
  read_two_a : assert property ( // [RULE3]
    @(posedge pclk) disable iff (!presetn)
      (psel && !pwrite && hit2) |-> prdata == {24'h00_0000, cfg2_q})
    else $error("second register read wrong");
  read_opt_a : assert property ( // [RULE19]
    @(posedge pclk) disable iff (!presetn)
      (psel && !pwrite && hit_opt) |-> prdata == {24'h00_0000, opt_q})
    else $error("option byte read wrong");
  // an unmapped access is flagged, a mapped one never
  map_err_a : assert property ( // [RULE4]
    @(posedge pclk) disable iff (!presetn)
      (psel && penable) |-> pslverr == (!(hit1 || hit2 || hit_opt) ||
        paddr[31:18] != 14'h0000))
    else $error("bus error flag wrong");
  // monitor in stop follows its enable while one circuit is powered
  mon_stop_a : assert property ( // [RULE7]
    @(posedge pclk) disable iff (!presetn)
      monitor_in_stop == (cfg1_q.monitor_stop_enable &&
        !(cfg1_q.supply_monitor_disable &&
          cfg1_q.regulator_monitor_disable)))
    else $error("monitor stop enable wrong");
  // monitor resets pass while the disable bit is clear
  mon_pass_a : assert property ( // [RULE9]
    @(posedge pclk) disable iff (!presetn)
      (!cfg1_q.monitor_reset_disable && monitor_reset_req) |->
        monitor_reset_out)
    else $error("monitor reset blocked while enabled");
  // each disable bit switches off its own monitor circuit
  mon_off_a : assert property ( // [RULE10]
    @(posedge pclk) disable iff (!presetn)
      supply_monitor_on == !cfg1_q.supply_monitor_disable &&
        regulator_monitor_on == !cfg1_q.regulator_monitor_disable)
    else $error("monitor circuit enable wrong");
  // recovery delay follows the short recovery bit off pin exits
  rec_sel_a : assert property ( // [RULE11]
    @(posedge pclk) disable iff (!presetn)
      !stop_exit_by_pin |-> recovery_cycles ==
        (cfg1_q.short_recovery_select ?
          13'(WOCR_REC_SHORT) : 13'(WOCR_REC_LONG)))
    else $error("recovery delay wrong");
  // short recovery with the monitor off in stop is flagged
  unprot_flag_a : assert property ( // [RULE14]
    @(posedge pclk) disable iff (!presetn)
      unprotected_start == (cfg1_q.short_recovery_select &&
        !monitor_in_stop))
    else $error("unprotected start-up flag wrong");
  // stop opcode and watchdog follow their bits
  stop_legal_a : assert property ( // [RULE15]
    @(posedge pclk) disable iff (!presetn)
      stop_opcode_legal == cfg1_q.stop_enable)
    else $error("stop opcode enable wrong");
  wd_run_a : assert property ( // [RULE16]
    @(posedge pclk) disable iff (!presetn)
      watchdog_enable == !cfg1_q.watchdog_disable)
    else $error("watchdog enable wrong");
  // outside stop every oscillator keeps running
  osc_run_a : assert property ( // [RULE17] [RULE18] [RULE20]
    @(posedge pclk) disable iff (!presetn)
      !stop_mode |-> int_osc_run && rc_osc_run && crystal_run)
    else $error("oscillator stopped outside stop mode");
  // in stop each oscillator follows its own bit
  osc_stop_a : assert property ( // [RULE17] [RULE18] [RULE20]
    @(posedge pclk) disable iff (!presetn)
      stop_mode |-> int_osc_run == !cfg2_q.int_osc_stop_disable &&
        rc_osc_run == cfg2_q.rc_osc_stop_enable &&
        crystal_run == cfg2_q.crystal_stop_enable)
    else $error("oscillator stop control wrong");
  // clock routing follows the second register
  clk_route_a : assert property ( // [RULE21] [RULE22]
    @(posedge pclk) disable iff (!presetn)
      timebase_src == cfg2_q.timebase_clk_sel &&
        serial_clk_bus == cfg2_q.serial_clk_source)
    else $error("clock routing wrong");
  // main oscillator select is the top pair of the option byte
  main_sel_a : assert property ( // [RULE23]
    @(posedge pclk) main_osc_sel == opt_q[7:6])
    else $error("main oscillator select wrong");
  // reset never touches the option byte, only flash strobes do
  opt_reset_a : assert property ( // [RULE23]
    @(posedge pclk)
      (!presetn && !opt_prog_we && !opt_erase) |=> $stable(opt_q))
    else $error("option byte changed by reset");
  // erase sets every bit, programming only clears bits
  opt_erase_a : assert property ( // [RULE19]
    @(posedge pclk) opt_erase |=> opt_q == WOCR_OPT_ERASED)
    else $error("option byte not erased");
  opt_prog_a : assert property ( // [RULE19]
    @(posedge pclk)
      (opt_prog_we && !opt_erase) |=>
        opt_q == ($past(opt_q) & $past(opt_prog_data)))
    else $error("option byte programmed wrong");
  // a bus write never reaches the option byte
  opt_bus_wr_a : assert property ( // [RULE19]
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && hit_opt && !opt_prog_we && !opt_erase) |=> $stable(opt_q))
    else $error("bus write reached the option byte");
endmodule

// *** tb/wocr_regs_tb.sv ***
`timescale 1ns/1ps
module wocr_regs_tb
  import wocr_pkg::*;
;
  typedef struct packed {
    logic [7:0] c1;                   // first register value
    logic [7:0] c2;                   // second register value
  } wocr_row_t;
  logic        pclk, presetn, psel, penable, pwrite;   // bus controls
  logic [31:0] paddr, pwdata, prdata, rd;             // bus data
  logic        pready, pslverr, err;                  // bus answer
  logic        opt_prog_we, opt_erase, stop_mode;     // flash and stop
  logic        stop_exit_by_pin, monitor_reset_req;   // stop and monitor
  logic [7:0]  opt_prog_data;                         // programmed byte
  logic        mon_rst, sup_on, reg_on, mon_stop, wd_en, unprot, stop_ok;
  logic        iosc, rosc, xosc, ser_bus;             // clock outputs
  logic [18:0] wd_to;                                 // watchdog cycles
  logic [12:0] rec;                                   // recovery cycles
  logic [1:0]  tb_src, mo_sel;                        // clock selects
  logic [7:0]  c1_out, c2_out;                        // register values
  int          bad_count, checked, cycles;            // report counters
  // ordinary cases: each bit set and cleared, every timebase code;
  // monitor reset disabled whenever stop would leave it unguarded
  wocr_row_t rows [6] = '{'{8'hff, 8'hff}, '{8'h20, 8'h00},
    '{8'haa, 8'h55}, '{8'h55, 8'haa}, '{8'h38, 8'h18}, '{8'h4c, 8'hc0}};
  wocr_regs u_wocr_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .opt_prog_we(opt_prog_we), .opt_prog_data(opt_prog_data),
    .opt_erase(opt_erase), .stop_mode(stop_mode),
    .stop_exit_by_pin(stop_exit_by_pin),
    .monitor_reset_req(monitor_reset_req), .monitor_reset_out(mon_rst),
    .supply_monitor_on(sup_on), .regulator_monitor_on(reg_on),
    .monitor_in_stop(mon_stop), .watchdog_enable(wd_en),
    .watchdog_timeout(wd_to), .recovery_cycles(rec),
    .unprotected_start(unprot), .stop_opcode_legal(stop_ok),
    .int_osc_run(iosc), .rc_osc_run(rosc), .crystal_run(xosc),
    .timebase_src(tb_src), .serial_clk_bus(ser_bus),
    .main_osc_sel(mo_sel), .cfg1_out(c1_out), .cfg2_out(c2_out));
  // clock at 20 MHz
  always #25 pclk = ~pclk;
  // hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      end_of_test();
    end
  end
  // verdict and end of run
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // value comparison
  task automatic chk(input string nm, input logic [31:0] exp, got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one bus transfer: setup, access until pready, one idle edge
  task automatic apb(input logic wr, input logic [31:0] a, d);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  // read a register and compare
  task automatic rdchk(input string nm, input logic [31:0] a, exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask
  // reset held five cycles
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  // flash strobe pulse for one cycle
  task automatic flash(input logic prog, input logic [7:0] v);
    opt_prog_we <= prog; opt_erase <= ~prog; opt_prog_data <= v;
    @(posedge pclk);
    opt_prog_we <= 1'b0; opt_erase <= 1'b0;
    @(posedge pclk);
  endtask
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; opt_prog_we = 0; opt_erase = 0;
    opt_prog_data = 0; stop_mode = 0; stop_exit_by_pin = 0;
    monitor_reset_req = 0; bad_count = 0; checked = 0; cycles = 0;
    // internal main clock so that short recovery rows are allowed
    @(posedge pclk);
    flash(1'b1, 8'h7f);
    foreach (rows[i]) begin
      do_reset();
      apb(1'b1, WOCR_ADDR_CFG1, {24'h0, rows[i].c1});
      apb(1'b1, WOCR_ADDR_CFG2, {24'h0, rows[i].c2});
      apb(1'b1, WOCR_ADDR_CFG1, {24'h0, ~rows[i].c1});
      apb(1'b1, WOCR_ADDR_CFG2, {24'h0, ~rows[i].c2});
      rdchk("cfg1", WOCR_ADDR_CFG1, rows[i].c1);
      rdchk("cfg2", WOCR_ADDR_CFG2, rows[i].c2 & 8'hf9);
      stop_mode <= 1'b1; monitor_reset_req <= 1'b1;
      @(negedge pclk);
      chk("mon_rst", !rows[i].c1[5], mon_rst);
      chk("sup_on", !rows[i].c1[4], sup_on);
      chk("reg_on", !rows[i].c1[3], reg_on);
      chk("mon_stop", rows[i].c1[6] & ~(rows[i].c1[4] & rows[i].c1[3]),
          mon_stop);
      chk("wd_en", !rows[i].c1[0], wd_en);
      chk("wd_to", rows[i].c1[7] ? 8176 : 262128, wd_to);
      chk("rec", rows[i].c1[2] ? 32 : 4096, rec);
      chk("stop_ok", rows[i].c1[1], stop_ok);
      chk("iosc", !rows[i].c2[7], iosc);
      chk("rosc", rows[i].c2[6], rosc);
      chk("xosc", rows[i].c2[5], xosc);
      chk("tb_src", rows[i].c2[4:3], tb_src);
      chk("ser_bus", rows[i].c2[0], ser_bus);
      chk("unprot", rows[i].c1[2] & !(rows[i].c1[6] &
          !(rows[i].c1[4] & rows[i].c1[3])), unprot);
      chk("c1_out", rows[i].c1, c1_out);
      chk("c2_out", rows[i].c2 & 8'hf9, c2_out);
      @(posedge pclk);
      stop_exit_by_pin <= 1'b1; monitor_reset_req <= 1'b0;
      @(negedge pclk);
      chk("rec_pin", 4096, rec);
      chk("mon_idle", 0, mon_rst);
      @(posedge pclk);
      stop_mode <= 1'b0; stop_exit_by_pin <= 1'b0;
      $display("test row %0d done", i);
    end
    do_reset();
    rdchk("cfg1_rst", WOCR_ADDR_CFG1, WOCR_CFG_RST);
    rdchk("cfg2_rst", WOCR_ADDR_CFG2, WOCR_CFG_RST);
    chk("mapped_err", 0, err);
    apb(1'b0, 32'h0000_0078, 32'h0);
    chk("unmapped_err", 1, err);
    chk("ready", 1, pready);
    $display("test reset and decode done");
    flash(1'b0, 8'h00);
    apb(1'b1, WOCR_ADDR_OPT, 32'h0000_0000);
    rdchk("opt_erased", WOCR_ADDR_OPT, WOCR_OPT_ERASED);
    chk("sel_xt", WOCR_MO_XT, mo_sel);
    flash(1'b1, 8'h7f);
    chk("sel_int", WOCR_MO_INT, mo_sel);
    do_reset();
    rdchk("opt_kept", WOCR_ADDR_OPT, 8'h7f);
    flash(1'b0, 8'h00);
    flash(1'b1, 8'hbf);
    chk("sel_rc", WOCR_MO_RC, mo_sel);
    $display("test option byte done");
    end_of_test();
  end
endmodule
